//--- hdl/drd_clock_divider.sv
// axi4-lite control and status around the dual ratio divider core
`include "drd_params.svh"
`default_nettype none
// Behaviour
// R1: fine path divides by 1,2,4,8; coarse path by 2,4,8,16; own selects.
// R2: both paths clocked from one input clock so shared edges coincide.
// R3: enable acts synchronously, switching only while the internal clock is low.
// R4: enable captured on input clock falling edge; driver times it to that edge.
// R5: on disable, dividers stop at the first falling edge afterwards.
// R6: while frozen every divider flop keeps its count state.
// R7: on re-enable, resume at next falling edge from held state, phase kept.
// R8: after clear release, outputs go high after the first rising clock edge.
// R9: each output frequency is input frequency over the selected ratio.
// R10: while clear is low, all divider flops go to one common initial state.
module drd_clock_divider #(
  parameter int CNT_W = `DRD_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`DRD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DRD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fine_ratio_out,
  output logic coarse_ratio_out
);

  drd_pkg::drd_ctrl_s ctrl_r;
  drd_pkg::drd_ctrl_s ctrl_nxt;
  logic aw_held_r;
  logic aw_held_nxt;
  logic [`DRD_ADDR_W-1:0] awaddr_r;
  logic [`DRD_ADDR_W-1:0] awaddr_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [7:0] wbyte_r;
  logic [7:0] wbyte_nxt;
  logic wstrb0_r;
  logic wstrb0_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic fine_level;
  logic run_state;
  logic [CNT_W-1:0] count;
  logic do_write;
  logic [31:0] status_word;

  // one decode serves both channels, so write and read maps cannot drift apart
  function automatic logic drd_is_ctrl(input logic [`DRD_ADDR_W-1:0] a);
    drd_is_ctrl = (a == `DRD_CTRL_OFS);
  endfunction : drd_is_ctrl

  function automatic logic drd_is_stat(input logic [`DRD_ADDR_W-1:0] a);
    drd_is_stat = (a == `DRD_STAT_OFS);
  endfunction : drd_is_stat

  // address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready = ~w_held_r;
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // live view: fields move between polls while the dividers run
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`DRD_STAT_RUN_BIT] = run_state;
    status_word[`DRD_STAT_FINE_BIT] = fine_level;
    status_word[`DRD_STAT_COARSE_BIT] = coarse_ratio_out;
    status_word[`DRD_STAT_CNT_LSB +: CNT_W] = count;
  end

  always_comb
  begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wbyte_nxt = wbyte_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    if (s_axi_awvalid && !aw_held_r)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r)
    begin
      w_held_nxt = 1'b1;
      wbyte_nxt = s_axi_wdata[7:0];
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      bvalid_nxt = 1'b1;
      if (drd_is_ctrl(awaddr_r))
      begin
        bresp_nxt = `DRD_RESP_OKAY;
        // select, freeze and clear bits steer the core from the next edge on
        if (wstrb0_r)
          ctrl_nxt = drd_pkg::drd_ctrl_s'(wbyte_r[5:0]); // [R1] [R5] [R7] [R10]
      end
      // status is read only: the write is answered and dropped
      else if (drd_is_stat(awaddr_r))
        bresp_nxt = `DRD_RESP_OKAY;
      // unmapped: refused with no side effect
      else
        bresp_nxt = `DRD_RESP_DECERR;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      // both channels stay shut until the response is taken: one write at a time
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b0;
    end
  end

  // read data registered, so it stands unchanged until rready
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      if (drd_is_ctrl(s_axi_araddr))
      begin
        rdata_nxt = {26'h0, ctrl_r};
        rresp_nxt = `DRD_RESP_OKAY;
      end
      else if (drd_is_stat(s_axi_araddr))
      begin
        rdata_nxt = status_word;
        rresp_nxt = `DRD_RESP_OKAY;
      end
      else
      begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `DRD_RESP_DECERR;
      end
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  // reset leaves the core running at its default ratios, ready for the first edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= drd_pkg::drd_ctrl_s'(`DRD_CTRL_RST);
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
      w_held_r <= 1'b0;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `DRD_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `DRD_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wbyte_r <= wbyte_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  drd_divider_core #(
    .CNT_W(CNT_W)
  ) u_core (
    .clk(clk),
    .rstn(rstn),
    .ctrl(ctrl_r),
    .fine_ratio_out(fine_ratio_out),
    .coarse_ratio_out(coarse_ratio_out),
    .fine_level(fine_level),
    .run_state(run_state),
    .count(count)
  );

endmodule : drd_clock_divider
`default_nettype wire

//--- hdl/drd_divider_core.sv
// shared down-counter with falling-edge run gate and per-path output taps
`include "drd_params.svh"
`default_nettype none
module drd_divider_core #(
  parameter int CNT_W = `DRD_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire drd_pkg::drd_ctrl_s ctrl,
  output logic fine_ratio_out,
  output logic coarse_ratio_out,
  output logic fine_level,
  output logic run_state,
  output logic [CNT_W-1:0] count
);

  logic run_r;
  logic run_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic fine_r;
  logic fine_nxt;
  logic coarse_r;
  logic coarse_nxt;

  function automatic logic drd_tap(input logic [CNT_W-1:0] c, input logic [1:0] idx);
    drd_tap = c[idx];
  endfunction : drd_tap

  // gate flop moves only on the falling edge, so the gated clock is low when it changes
  always_comb
  begin
    run_nxt = ~ctrl.freeze & ctrl.clear_n; // [R3] [R4]
  end

  always_ff @(negedge clk or negedge rstn)
  begin
    if (!rstn)
      run_r <= `DRD_RUN_RST;
    else
      run_r <= run_nxt; // [R4] [R5] [R7]
  end

  // one counter feeds both paths, so shared edges line up
  always_comb
  begin
    if (!ctrl.clear_n)
      cnt_nxt = CNT_W'(`DRD_CNT_RST); // [R10]
    else if (run_r)
      cnt_nxt = CNT_W'(cnt_r - 1'b1); // [R2] [R7] [R9]
    else
      cnt_nxt = cnt_r; // [R6]
    // down-count from zero makes every tap rise on the first edge after clear
    if (!ctrl.clear_n)
    begin
      fine_nxt = 1'b0;
      coarse_nxt = 1'b0;
    end
    else
    begin
      fine_nxt = drd_tap(cnt_nxt, 2'(ctrl.fine_sel - 2'h1)); // [R1] [R8] [R9]
      coarse_nxt = drd_tap(cnt_nxt, ctrl.coarse_sel); // [R1] [R8] [R9]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= CNT_W'(`DRD_CNT_RST);
      fine_r <= 1'b0;
      coarse_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      fine_r <= fine_nxt;
      coarse_r <= coarse_nxt;
    end
  end

  // divide by one is the gated clock itself; a select change while clk is high may glitch
  assign fine_ratio_out = (ctrl.fine_sel == drd_pkg::DRD_FINE_DIV1) ? (clk & run_r) : fine_r; // [R1] [R3]
  assign coarse_ratio_out = coarse_r;
  assign fine_level = fine_r;
  assign run_state = run_r;
  assign count = cnt_r;

endmodule : drd_divider_core
`default_nettype wire

//--- hdl/drd_params.svh
// offsets, field positions, reset values and response codes of the dual ratio divider
`ifndef DRD_PARAMS_SVH
`define DRD_PARAMS_SVH

`define DRD_ADDR_W 4
`define DRD_CTRL_OFS 4'h0
`define DRD_STAT_OFS 4'h4

`define DRD_CTRL_FINE_LSB 0
`define DRD_CTRL_COARSE_LSB 2
`define DRD_CTRL_FREEZE_BIT 4
`define DRD_CTRL_CLEAR_N_BIT 5
`define DRD_CTRL_RST 6'h20

`define DRD_STAT_RUN_BIT 0
`define DRD_STAT_FINE_BIT 1
`define DRD_STAT_COARSE_BIT 2
`define DRD_STAT_CNT_LSB 4

`define DRD_RUN_RST 1'h1
`define DRD_CNT_RST 4'h0
`define DRD_CNT_W 4

`define DRD_RESP_OKAY 2'h0
`define DRD_RESP_DECERR 2'h3

`endif

//--- hdl/drd_pkg.sv
// types shared by the dual ratio divider files
`default_nettype none
package drd_pkg;

  typedef struct packed {
    logic clear_n;
    logic freeze;
    logic [1:0] coarse_sel;
    logic [1:0] fine_sel;
  } drd_ctrl_s;

  typedef enum logic [1:0] {
    DRD_FINE_DIV1 = 2'h0,
    DRD_FINE_DIV2 = 2'h1,
    DRD_FINE_DIV4 = 2'h2,
    DRD_FINE_DIV8 = 2'h3
  } drd_fine_e;

endpackage : drd_pkg
`default_nettype wire

//--- tb/drd_clock_divider_checker.sv
// handshake and release checks for the dual ratio divider
`default_nettype none
module drd_clock_divider_checker #(
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic coarse_ratio_out
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence bus_free;
    !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endsequence
  write_answer_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> bus_free)
    else $error("write not closed");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read not closed");
  read_free_a: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
    else $error("read address stuck");
  release_high_a: assert property ($rose(rstn) |=> coarse_ratio_out)
    else $error("output low after release");
endmodule : drd_clock_divider_checker
bind drd_clock_divider drd_clock_divider_checker #(.CNT_W(CNT_W)) u_chk (
  .clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .coarse_ratio_out
);
`default_nettype wire

//--- tb/drd_load_model.sv
// clock load that counts rising edges of both divided outputs
`default_nettype none
module drd_load_model (
  input wire logic fine,
  input wire logic coarse,
  output var int fine_rises,
  output var int coarse_rises
);
  timeunit 1ns / 1ps;
  initial fine_rises = 0;
  initial coarse_rises = 0;
  always @(posedge fine) fine_rises++;
  always @(posedge coarse) coarse_rises++;
endmodule : drd_load_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the dual ratio divider
`include "drd_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns / 1ps;
  localparam logic [3:0] CA = `DRD_CTRL_OFS;
  localparam logic [3:0] SA = `DRD_STAT_OFS;
  localparam logic [1:0] OK = `DRD_RESP_OKAY;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fine_ratio_out, coarse_ratio_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, st;
  int fail_count = 0;
  int n_tests = 0;
  int fr, cr;
  always #5 clk = ~clk;
  drd_clock_divider dut (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fine_ratio_out, .coarse_ratio_out
  );
  drd_load_model lm (.fine(fine_ratio_out), .coarse(coarse_ratio_out), .fine_rises(fr),
    .coarse_rises(cr));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er,
    input logic [3:0] s = 4'hF);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er,
    input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    st = s_axi_rdata;
    chk("rdata", e, st & m);
    chk("rresp", er, s_axi_rresp);
  endtask : rdc
  function automatic logic [31:0] ctl(input int f, input int c, input int z, input int l);
    return {26'h0, l[0], z[0], c[1:0], f[1:0]};
  endfunction : ctl
  function automatic int rises(input int w, input int sh, input bit on);
    return on ? w >> sh : 0;
  endfunction : rises
  // upper bits random: only the low six may stick
  task automatic wc(input int f, input int c, input int z, input int l);
    wr(CA, ($urandom & 32'hFFFFFFC0) | ctl(f, c, z, l), OK);
  endtask : wc
  // windows are multiples of 16 so any phase of a steady output gives exact counts
  task automatic meas(input int w, input int sf, input int sc, input bit on);
    int f0;
    int c0;
    @(negedge clk);
    f0 = fr;
    c0 = cr;
    repeat (w) @(negedge clk);
    chk("fine rises", rises(w, sf, on), fr - f0);
    chk("coarse rises", rises(w, sc, on), cr - c0);
  endtask : meas
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    logic [31:0] h;
    void'($urandom(32'hB9186DDC));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdc(CA, `DRD_CTRL_RST, OK);
    meas(64, 0, 1, 1'b1);
    $display("test reset release done");
    for (int i = 0; i < 16; i++)
    begin
      wc(i % 4, i / 4, 0, 1);
      rdc(CA, ctl(i % 4, i / 4, 0, 1), OK);
      meas(64, i % 4, i / 4 + 1, 1'b1);
      wc(i % 4, i / 4, 1, 1);
      meas(32, 0, 0, 1'b0);
      rdc(SA, 32'h0, OK, 32'h1);
      h = st;
      repeat ($urandom_range(1, 20)) @(posedge clk);
      rdc(SA, h, OK);
      wc(i % 4, i / 4, 0, 1);
      meas(64, i % 4, i / 4 + 1, 1'b1);
      wc(i % 4, i / 4, 0, 0);
      rdc(SA, 32'h0, OK);
      meas(32, 0, 0, 1'b0);
      wc(i % 4, i / 4, 0, 1);
      meas(64, i % 4, i / 4 + 1, 1'b1);
      $display("test ratio pair %0d done", i);
    end
    rdc(4'h8, 32'h0, `DRD_RESP_DECERR);
    wr(4'hC, 32'h0, `DRD_RESP_DECERR);
    wr(CA, 32'h0, OK, 4'h0);
    wr(SA, 32'h0, OK);
    rdc(CA, ctl(3, 3, 0, 1), OK);
    $display("test bus corners done");
    finish_test();
  end
  initial
  begin
    #200us;
    fail_count++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
